// File: inc/csr_pkg.sv
// Shared constants and types of the colour sensor result and configuration bank
package csr_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 7;
	localparam int CHAN_N = 5;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h93;
	localparam logic [7:0] ADDR_Z_LOW = 8'h94;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h95;
	localparam logic [7:0] ADDR_Y_LOW = 8'h96;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h97;
	localparam logic [7:0] ADDR_IRA_LOW = 8'h98;
	localparam logic [7:0] ADDR_IRA_HIGH = 8'h99;
	localparam logic [7:0] ADDR_CH3_LOW = 8'h9A;
	localparam logic [7:0] ADDR_CH3_HIGH = 8'h9B;
	localparam logic [7:0] ADDR_GAIN_EXT = 8'h9F;
	localparam logic [7:0] ADDR_SLEEP_CFG = 8'hAB;
	localparam logic [7:0] ADDR_AZ_CFG = 8'hD6;
	localparam logic [7:0] ADDR_IRQ_EN = 8'hDD;

	// ****************************************
	// Field positions and values
	// ****************************************
	localparam int BIT_HIGH_GAIN_EXTENSION = 4;
	localparam int BIT_LOW_GAIN_EXTENSION = 3;
	localparam int BIT_RD_CLR = 7;
	localparam int BIT_SAI = 4;
	localparam int BIT_OFFSET_SEARCH_START_MODE = 7;
	localparam int BIT_SAT = 7;
	localparam int BIT_LIGHT = 4;
	localparam int BIT_CALIB = 3;
	localparam logic [7:0] STATUS_MASK = 8'h98;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] AZ_CFG_RST = 8'h7F;
	localparam logic [6:0] AZ_NEVER = 7'h00;
	localparam logic [6:0] AZ_FIRST_ONLY = 7'h7F;
	localparam logic [6:0] AZ_STEP = 7'h01;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] CNT_BYTE = 4'h8;
	localparam logic [1:0] BASE_1X = 2'h0;
	localparam logic [1:0] BASE_4X = 2'h1;
	localparam logic [1:0] BASE_16X = 2'h2;
	localparam logic [1:0] BASE_64X = 2'h3;

	// Applied analog gain
	typedef enum logic [2:0] {
		GAIN_QUARTER = 3'h0,
		GAIN_1X = 3'h1,
		GAIN_4X = 3'h2,
		GAIN_16X = 3'h3,
		GAIN_64X = 3'h4,
		GAIN_128X = 3'h5
	} csr_gain_e;

	// Serial slave states, Gray coded along the usual path
	typedef enum logic [3:0] {
		I2C_IDLE = 4'h0,
		I2C_ADDR = 4'h1,
		I2C_ADDR_ACK = 4'h3,
		I2C_REG = 4'h2,
		I2C_REG_ACK = 4'h6,
		I2C_WDATA = 4'h7,
		I2C_WDATA_ACK = 4'h5,
		I2C_RDATA = 4'h4,
		I2C_RDATA_ACK = 4'hC
	} csr_i2c_e;

endpackage : csr_pkg

// File: src/csr_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module csr_sync
#(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)
(
	// Clock and reset of the receiving domain
	input wire logic clock,
	input wire logic rst_n,
	// Foreign value in, accepted value out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} csr_sync_s;

	csr_sync_s r;
	csr_sync_s next_r;

	// Stage one feeds only stage two; the filter compares stages two and three
	always_comb
	begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.q = (r.s2 == r.s3) ? r.s3 : r.q;
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
		else
			r <= next_r;
	end

	assign q = r.q;

endmodule : csr_sync
`default_nettype wire

// File: src/csr_regs.sv
// Colour sensor result, gain extension, sleep, auto-zero and interrupt enable registers
`timescale 1ns/10ps
`default_nettype none
module csr_regs
	import csr_pkg::*;
#(
	parameter logic [ADDR_W-1:0] DEV_ADDR = 7'h39
)
(
	// System clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial bus pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Interrupt pin, open drain, active low
	output logic int_n_out,
	output logic int_n_oe,
	// Levels and events from neighbouring registers
	input wire logic power_on,
	input wire logic channel_three_select,
	input wire logic [1:0] base_gain_field,
	input wire logic sat_detect,
	input wire logic light_detect,
	input wire logic calib_detect,
	// Analog controls
	output logic osc_enable,
	output var csr_gain_e gain_select,
	// Measurement side, oscillator domain
	input wire logic osc_clock,
	input wire logic osc_rst_n,
	input wire logic adc_done,
	input wire logic als_cycle_start,
	input wire logic [WORD_W-1:0] z_data,
	input wire logic [WORD_W-1:0] y_data,
	input wire logic [WORD_W-1:0] ir1_data,
	input wire logic [WORD_W-1:0] x_data,
	input wire logic [WORD_W-1:0] ir2_data,
	output logic az_run,
	output logic az_resume
);

	// ****************************************
	// State of both domains
	// ****************************************
	typedef struct packed {
		csr_i2c_e state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic nack;
		logic drive;
		logic scl_p;
		logic sda_p;
		logic high_gain_extension;
		logic low_gain_extension;
		logic rd_clr;
		logic sleep_after_irq;
		logic [7:0] az_cfg;
		logic sat_en;
		logic light_en;
		logic [7:0] status;
		logic [CHAN_N-1:0][WORD_W-1:0] res;
		logic ack;
		logic irq;
		logic osc_en;
		csr_gain_e gain;
	} csr_sys_s;

	typedef struct packed {
		logic req;
		logic [CHAN_N-1:0][WORD_W-1:0] hold;
		logic first;
		logic [6:0] cyc;
		logic az_run;
		logic az_resume;
	} csr_osc_s;

	localparam csr_sys_s SYS_RST = '{state: I2C_IDLE, az_cfg: AZ_CFG_RST, scl_p: 1'b1, sda_p: 1'b1,
		gain: GAIN_1X, default: '0};
	localparam csr_osc_s OSC_RST = '{first: 1'b1, default: '0};

	csr_sys_s r;
	csr_sys_s next_r;
	csr_osc_s o;
	csr_osc_s next_o;
	logic [1:0] pin_q;
	logic req_q;
	logic ack_q;
	logic [7:0] az_q;

	// ****************************************
	// Domain crossings
	// ****************************************
	// Pins are filtered together so start and stop see one consistent picture
	csr_sync #(.W(2), .INIT(2'h3)) u_pins (
		.clock(clock),
		.rst_n(rst_n),
		.d({scl, sda_in}),
		.q(pin_q)
	);

	// Result handshake, request toward the system clock
	csr_sync #(.W(1), .INIT(1'b0)) u_req (
		.clock(clock),
		.rst_n(rst_n),
		.d(o.req),
		.q(req_q)
	);

	// Result handshake, acknowledge toward the oscillator clock
	csr_sync #(.W(1), .INIT(1'b0)) u_ack (
		.clock(osc_clock),
		.rst_n(osc_rst_n),
		.d(r.ack),
		.q(ack_q)
	);

	// Auto-zero setup is quasi-static; a write mid-cycle may be seen one cycle late
	csr_sync #(.W(8), .INIT(AZ_CFG_RST)) u_azcfg (
		.clock(osc_clock),
		.rst_n(osc_rst_n),
		.d(r.az_cfg),
		.q(az_q)
	);

	// ****************************************
	// Register read decode
	// ****************************************
	// Unmapped offsets read as zero
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] v;
		logic [WORD_W-1:0] ch3;
		v = BYTE_ZERO;
		ch3 = channel_three_select ? r.res[4] : r.res[3];
		case (a)
			ADDR_STATUS: v = r.status;
			ADDR_Z_LOW: v = r.res[0][7:0];
			ADDR_Z_HIGH: v = r.res[0][15:8];
			ADDR_Y_LOW: v = r.res[1][7:0];
			ADDR_Y_HIGH: v = r.res[1][15:8];
			ADDR_IRA_LOW: v = r.res[2][7:0];
			ADDR_IRA_HIGH: v = r.res[2][15:8];
			ADDR_CH3_LOW: v = ch3[7:0];
			ADDR_CH3_HIGH: v = ch3[15:8];
			ADDR_GAIN_EXT:
			begin
				v[BIT_HIGH_GAIN_EXTENSION] = r.high_gain_extension;
				v[BIT_LOW_GAIN_EXTENSION] = r.low_gain_extension;
			end
			ADDR_SLEEP_CFG:
			begin
				v[BIT_RD_CLR] = r.rd_clr;
				v[BIT_SAI] = r.sleep_after_irq;
			end
			ADDR_AZ_CFG: v = r.az_cfg;
			ADDR_IRQ_EN:
			begin
				v[BIT_SAT] = r.sat_en;
				v[BIT_LIGHT] = r.light_en;
			end
			default: v = BYTE_ZERO;
		endcase
		return v;
	endfunction : reg_read

	// ****************************************
	// System domain: serial slave and registers
	// ****************************************
	// Slave, register writes, status flags, gain, interrupt and oscillator gate
	always_comb
	begin
		logic scl_f;
		logic sda_f;
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic wr_stb;
		logic rd_stb;
		logic [7:0] rd;
		logic [7:0] clr;
		logic [7:0] set;
		scl_f = pin_q[1];
		sda_f = pin_q[0];
		scl_rise = scl_f & ~r.scl_p;
		scl_fall = ~scl_f & r.scl_p;
		start_c = scl_f & r.scl_p & r.sda_p & ~sda_f;
		stop_c = scl_f & r.scl_p & ~r.sda_p & sda_f;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		rd = BYTE_ZERO;
		clr = BYTE_ZERO;
		set = BYTE_ZERO;
		next_r = r;
		next_r.scl_p = scl_f;
		next_r.sda_p = sda_f;
		if (start_c)
		begin
			next_r.state = I2C_ADDR;
			next_r.cnt = '0;
			next_r.drive = 1'b0;
		end
		else if (stop_c)
		begin
			next_r.state = I2C_IDLE;
			next_r.drive = 1'b0;
		end
		else if (scl_rise)
		begin
			case (r.state)
				I2C_ADDR, I2C_REG, I2C_WDATA:
				begin
					next_r.shift = {r.shift[6:0], sda_f};
					next_r.cnt = r.cnt + CNT_ONE;
				end
				I2C_RDATA_ACK: next_r.nack = sda_f;
				default: next_r.nack = r.nack;
			endcase
		end
		else if (scl_fall)
		begin
			case (r.state)
				I2C_IDLE: next_r.drive = 1'b0;
				I2C_ADDR:
				begin
					if (r.cnt == CNT_BYTE)
					begin
						if (r.shift[7:1] == DEV_ADDR)
						begin
							next_r.state = I2C_ADDR_ACK;
							next_r.drive = 1'b1;
							next_r.rw = r.shift[0];
						end
						else
							next_r.state = I2C_IDLE;
					end
				end
				I2C_ADDR_ACK:
				begin
					next_r.drive = 1'b0;
					next_r.cnt = '0;
					if (r.rw)
						rd_stb = 1'b1;
					else
						next_r.state = I2C_REG;
				end
				I2C_REG:
				begin
					if (r.cnt == CNT_BYTE)
					begin
						next_r.ptr = r.shift;
						next_r.drive = 1'b1;
						next_r.state = I2C_REG_ACK;
					end
				end
				I2C_WDATA:
				begin
					if (r.cnt == CNT_BYTE)
					begin
						wr_stb = 1'b1;
						next_r.ptr = r.ptr + PTR_STEP;
						next_r.drive = 1'b1;
						next_r.state = I2C_WDATA_ACK;
					end
				end
				I2C_REG_ACK, I2C_WDATA_ACK:
				begin
					next_r.drive = 1'b0;
					next_r.cnt = '0;
					next_r.state = I2C_WDATA;
				end
				I2C_RDATA:
				begin
					if (r.cnt == CNT_BYTE)
					begin
						next_r.drive = 1'b0;
						next_r.state = I2C_RDATA_ACK;
					end
					else
					begin
						next_r.drive = ~r.shift[7];
						next_r.shift = {r.shift[6:0], 1'b0};
						next_r.cnt = r.cnt + CNT_ONE;
					end
				end
				I2C_RDATA_ACK:
				begin
					if (r.nack)
						next_r.state = I2C_IDLE;
					else
						rd_stb = 1'b1;
				end
				default: next_r.state = I2C_IDLE;
			endcase
		end
		// Load the next byte to send; the pointer steps after every byte
		if (rd_stb)
		begin
			rd = reg_read(r.ptr);
			next_r.drive = ~rd[7];
			next_r.shift = {rd[6:0], 1'b0};
			next_r.cnt = CNT_ONE;
			next_r.ptr = r.ptr + PTR_STEP;
			next_r.state = I2C_RDATA;
		end
		// Register writes; result bytes and status have no stored write
		if (wr_stb)
		begin
			case (r.ptr)
				ADDR_GAIN_EXT:
				begin
					next_r.high_gain_extension = r.shift[BIT_HIGH_GAIN_EXTENSION];
					next_r.low_gain_extension = r.shift[BIT_LOW_GAIN_EXTENSION];
				end
				ADDR_SLEEP_CFG:
				begin
					next_r.rd_clr = r.shift[BIT_RD_CLR];
					next_r.sleep_after_irq = r.shift[BIT_SAI];
				end
				ADDR_AZ_CFG: next_r.az_cfg = r.shift;
				ADDR_IRQ_EN:
				begin
					next_r.sat_en = r.shift[BIT_SAT];
					next_r.light_en = r.shift[BIT_LIGHT];
				end
				default: next_r.az_cfg = r.az_cfg;
			endcase
		end
		// Status flags: an event in the clearing cycle survives the clear
		if (wr_stb && (r.ptr == ADDR_STATUS))
			clr = r.shift & STATUS_MASK;
		if (rd_stb && (r.ptr == ADDR_STATUS) && r.rd_clr)
			clr = STATUS_MASK;
		set[BIT_SAT] = sat_detect;
		set[BIT_LIGHT] = light_detect;
		set[BIT_CALIB] = calib_detect;
		next_r.status = (r.status & ~clr) | set;
		// Take a new result set when the oscillator side toggles its request
		if (req_q != r.ack)
		begin
			next_r.res = o.hold;
			next_r.ack = ~r.ack;
		end
		// Applied gain from base field and extensions
		case (base_gain_field)
			BASE_1X: next_r.gain = r.low_gain_extension ? GAIN_QUARTER : GAIN_1X;
			BASE_4X: next_r.gain = GAIN_4X;
			BASE_16X: next_r.gain = GAIN_16X;
			BASE_64X: next_r.gain = r.high_gain_extension ? GAIN_128X : GAIN_64X;
			default: next_r.gain = GAIN_1X;
		endcase
		// Interrupt line from enabled flags only
		next_r.irq = (r.status[BIT_SAT] & r.sat_en)
			| (r.status[BIT_LIGHT] & r.light_en);
		// Sleep acts only through the asserted line; clearing flags restarts
		next_r.osc_en = power_on & ~(r.sleep_after_irq & r.irq);
	end

	// System state register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			r <= SYS_RST;
		else
			r <= next_r;
	end

	// ****************************************
	// Oscillator domain: capture and auto-zero
	// ****************************************
	// The clock stops when gated, so nothing here waits on the system side
	always_comb
	begin
		next_o = o;
		next_o.az_run = 1'b0;
		next_o.az_resume = az_q[BIT_OFFSET_SEARCH_START_MODE];
		// Capture only when the previous set was taken, else the set is dropped
		if (adc_done && (o.req == ack_q))
		begin
			next_o.hold = {ir2_data, x_data, ir1_data, y_data, z_data};
			next_o.req = ~o.req;
		end
		// Auto-zero schedule counted in light cycles
		if (als_cycle_start && (az_q[6:0] != AZ_NEVER))
		begin
			if (o.first)
			begin
				next_o.az_run = 1'b1;
				next_o.first = 1'b0;
				next_o.cyc = '0;
			end
			else if (az_q[6:0] != AZ_FIRST_ONLY)
			begin
				if ((o.cyc + AZ_STEP) == az_q[6:0])
				begin
					next_o.az_run = 1'b1;
					next_o.cyc = '0;
				end
				else
					next_o.cyc = o.cyc + AZ_STEP;
			end
		end
	end

	// Oscillator state register
	always_ff @(posedge osc_clock)
	begin
		if (!osc_rst_n)
			o <= OSC_RST;
		else
			o <= next_o;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sda_out = 1'b0;
	assign sda_oe = r.drive;
	assign int_n_out = 1'b0;
	assign int_n_oe = r.irq;
	assign osc_enable = r.osc_en;
	assign gain_select = r.gain;
	assign az_run = o.az_run;
	assign az_resume = o.az_resume;

endmodule : csr_regs
`default_nettype wire

// File: sim/csr_regs_properties.sv
// Port checks of the colour sensor register bank
`timescale 1ns/10ps
`default_nettype none
module csr_regs_properties
	import csr_pkg::*;
(
	// Clocks and resets of both domains
	input wire logic clock,
	input wire logic rst_n,
	input wire logic osc_clock,
	input wire logic osc_rst_n,
	// Watched levels
	input wire logic power_on,
	input wire logic [1:0] base_gain_field,
	input wire logic int_n_oe,
	input wire logic osc_enable,
	input wire csr_gain_e gain_select,
	input wire logic als_cycle_start,
	input wire logic az_run
);
	// ****************************************
	// Gating, gain and offset search
	// ****************************************
	a_osc_off_unpowered: assert property (@(posedge clock) disable iff (!rst_n)
		!power_on |=> !osc_enable) else $error("oscillator runs without power-on");
	a_osc_runs_idle: assert property (@(posedge clock) disable iff (!rst_n)
		power_on && !int_n_oe |=> osc_enable) else $error("oscillator stopped without cause");
	a_sleep_via_irq: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(osc_enable) && $past(power_on) |-> $past(int_n_oe)) else $error("sleep without interrupt");
	a_gain_four: assert property (@(posedge clock) disable iff (!rst_n)
		base_gain_field == BASE_4X |=> gain_select == GAIN_4X) else $error("gain not 4x");
	a_gain_sixteen: assert property (@(posedge clock) disable iff (!rst_n)
		base_gain_field == BASE_16X |=> gain_select == GAIN_16X) else $error("gain not 16x");
	a_gain_low_ext: assert property (@(posedge clock) disable iff (!rst_n)
		base_gain_field == BASE_1X |=> gain_select inside {GAIN_QUARTER, GAIN_1X}) else $error("bad low gain");
	a_gain_high_ext: assert property (@(posedge clock) disable iff (!rst_n)
		base_gain_field == BASE_64X |=> gain_select inside {GAIN_64X, GAIN_128X}) else $error("bad high gain");
	a_az_on_start: assert property (@(posedge osc_clock) disable iff (!osc_rst_n)
		az_run |-> $past(als_cycle_start)) else $error("offset search without cycle start");
	a_az_one_pulse: assert property (@(posedge osc_clock) disable iff (!osc_rst_n)
		az_run |=> !az_run) else $error("offset search pulse too long");
	// Main scenarios reached
	c_sleep: cover property (@(posedge clock) disable iff (!rst_n) $fell(osc_enable) && power_on);
	c_gain_top: cover property (@(posedge clock) disable iff (!rst_n) gain_select == GAIN_128X);
	c_az: cover property (@(posedge osc_clock) disable iff (!osc_rst_n) az_run);
endmodule : csr_regs_properties
`default_nettype wire

// File: sim/csr_host.sv
// Serial bus controller model standing for the host processor
`timescale 1ns/10ps
`default_nettype none
module csr_host
#(
	parameter logic [6:0] DEV = 7'h39
)
(
	// Pacing clock and wire level with pull-up
	input wire logic clock,
	input wire logic sda_line,
	// Driven pins, one means released
	output logic scl,
	output logic sda_drv
);
	logic ack;
	logic nak;
	// Idle bus until the first transfer
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
		nak = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask : w
	// Data changes four clocks after the fall, keeping hold time past the pin filter
	task automatic bit_io(input logic b, output logic s);
		w(4);
		sda_drv <= b;
		w(6);
		scl <= 1'b1;
		w(5);
		s = sda_line;
		w(5);
		scl <= 1'b0;
	endtask : bit_io
	// Ninth slot always released: writes sample the acknowledge, reads send not-acknowledge
	task automatic byte_io(input logic [7:0] d, input logic rx, output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, ack);
		if (!rx)
			nak = nak | ack;
	endtask : byte_io
	task automatic start;
		w(4);
		sda_drv <= 1'b1;
		w(6);
		scl <= 1'b1;
		w(10);
		sda_drv <= 1'b0;
		w(10);
		scl <= 1'b0;
	endtask : start
	task automatic stop;
		w(4);
		sda_drv <= 1'b0;
		w(6);
		scl <= 1'b1;
		w(10);
		sda_drv <= 1'b1;
		w(10);
	endtask : stop
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		byte_io({DEV, 1'b0}, 1'b0, q);
		byte_io(a, 1'b0, q);
		byte_io(d, 1'b0, q);
		stop();
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		byte_io({DEV, 1'b0}, 1'b0, q);
		byte_io(a, 1'b0, q);
		start();
		byte_io({DEV, 1'b1}, 1'b0, q);
		byte_io(8'hFF, 1'b1, d);
		stop();
	endtask : rd_reg
endmodule : csr_host
`default_nettype wire

// File: sim/csr_regs_tb.sv
// Self-checking bench for the colour sensor register bank
`timescale 1ns/10ps
`default_nettype none
module csr_regs_tb
	import csr_pkg::*;
;
	logic clock, rst_n, osc_clock, osc_rst_n, scl, sda_drv, sda_in, sda_out, sda_oe, int_n_out, int_n_oe;
	logic power_on, channel_three_select, sat_detect, light_detect, calib_detect, osc_enable;
	logic adc_done, als_cycle_start, az_run, az_resume;
	logic [1:0] base_gain_field;
	logic [WORD_W-1:0] z_data, y_data, ir1_data, x_data, ir2_data;
	csr_gain_e gain_select;
	logic [7:0] rd;
	int num_errors, compares, cycles, runs;
	// Pulled-up data wire
	assign sda_in = sda_drv & (sda_oe ? sda_out : 1'b1);
	csr_regs csr_regs_i (.clock, .rst_n, .scl, .sda_in, .sda_out, .sda_oe, .int_n_out, .int_n_oe, .power_on,
		.channel_three_select, .base_gain_field, .sat_detect, .light_detect, .calib_detect, .osc_enable,
		.gain_select, .osc_clock, .osc_rst_n, .adc_done, .als_cycle_start, .z_data, .y_data, .ir1_data,
		.x_data, .ir2_data, .az_run, .az_resume);
	csr_host csr_host_i (.clock, .sda_line(sda_in), .scl, .sda_drv);
	// Clocks; the oscillator clock phase never meets a system edge
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial
	begin
		osc_clock = 1'b0;
		#7;
		// The oscillator model stands still while the block gates it off, keeping its phase grid
		forever
			#15 if (osc_enable || !osc_rst_n) osc_clock = ~osc_clock;
	end
	// Hang guard and offset search counter
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			num_errors++;
			results();
		end
	end
	always @(posedge osc_clock)
		if (az_run === 1'b1)
			runs++;
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk_byte
	task automatic chk_bit(input string n, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
		csr_host_i.rd_reg(a, rd);
		chk_byte("register", e, rd);
	endtask : reg_chk
	// Raise detect inputs for one clock: sat, light, calib
	task automatic flag(input logic [2:0] m);
		{sat_detect, light_detect, calib_detect} <= m;
		tick(1);
		{sat_detect, light_detect, calib_detect} <= 3'h0;
		tick(3);
	endtask : flag
	task automatic starts(input int n);
		runs = 0;
		repeat (n)
		begin
			@(posedge osc_clock) als_cycle_start <= 1'b1;
			@(posedge osc_clock) als_cycle_start <= 1'b0;
			repeat (6) @(posedge osc_clock);
		end
	endtask : starts
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		for (int a = 8'h94; a <= 8'h9B; a++)
			reg_chk(a[7:0], 8'h00);
		reg_chk(ADDR_AZ_CFG, AZ_CFG_RST);
		reg_chk(ADDR_IRQ_EN, 8'h00);
		reg_chk(8'hC0, 8'h00);
		chk_bit("ack", 1'b0, csr_host_i.nak);
	endtask : t_reset
	task automatic t_results;
		@(posedge osc_clock) {z_data, y_data, ir1_data, x_data, ir2_data} <= 80'hA1B2_C3D4_E5F6_0718_293A;
		adc_done <= 1'b1;
		@(posedge osc_clock) adc_done <= 1'b0;
		tick(20);
		csr_host_i.wr_reg(ADDR_Z_LOW, 8'h5A);
		reg_chk(ADDR_Z_LOW, 8'hB2);
		reg_chk(ADDR_Z_HIGH, 8'hA1);
		reg_chk(ADDR_Y_LOW, 8'hD4);
		reg_chk(ADDR_Y_HIGH, 8'hC3);
		reg_chk(ADDR_IRA_LOW, 8'hF6);
		reg_chk(ADDR_IRA_HIGH, 8'hE5);
		reg_chk(ADDR_CH3_LOW, 8'h18);
		reg_chk(ADDR_CH3_HIGH, 8'h07);
		channel_three_select <= 1'b1;
		reg_chk(ADDR_CH3_HIGH, 8'h29);
		reg_chk(ADDR_CH3_LOW, 8'h3A);
		channel_three_select <= 1'b0;
	endtask : t_results
	task automatic t_gain;
		csr_gain_e e;
		for (int b = 0; b < 4; b++)
			for (int x = 0; x < 3; x++)
			begin
				base_gain_field <= b[1:0];
				csr_host_i.wr_reg(ADDR_GAIN_EXT, x == 1 ? 8'h08 : x == 2 ? 8'h10 : 8'h00);
				tick(4);
				e = b == 0 ? (x == 1 ? GAIN_QUARTER : GAIN_1X) : b == 1 ? GAIN_4X : b == 2 ? GAIN_16X :
					(x == 2 ? GAIN_128X : GAIN_64X);
				chk_byte("gain", {5'h00, e}, {5'h00, gain_select});
			end
	endtask : t_gain
	task automatic t_irq;
		csr_host_i.wr_reg(ADDR_IRQ_EN, 8'h80);
		flag(3'h1);
		flag(3'h2);
		chk_bit("irq", 1'b0, int_n_oe);
		flag(3'h4);
		chk_bit("irq", 1'b1, int_n_oe);
		reg_chk(ADDR_STATUS, 8'h98);
		csr_host_i.wr_reg(ADDR_STATUS, 8'h80);
		reg_chk(ADDR_STATUS, 8'h18);
		chk_bit("irq", 1'b0, int_n_oe);
		csr_host_i.wr_reg(ADDR_IRQ_EN, 8'h10);
		csr_host_i.wr_reg(ADDR_SLEEP_CFG, 8'h10);
		tick(3);
		chk_bit("irq", 1'b1, int_n_oe);
		chk_bit("int pin", 1'b0, int_n_oe ? int_n_out : 1'b1);
		chk_bit("osc", 1'b0, osc_enable);
		reg_chk(ADDR_SLEEP_CFG, 8'h10);
		csr_host_i.wr_reg(ADDR_STATUS, 8'h18);
		tick(3);
		chk_bit("osc", 1'b1, osc_enable);
		power_on <= 1'b0;
		tick(3);
		chk_bit("osc", 1'b0, osc_enable);
		power_on <= 1'b1;
		csr_host_i.wr_reg(ADDR_SLEEP_CFG, 8'h80);
		flag(3'h4);
		reg_chk(ADDR_STATUS, 8'h80);
		reg_chk(ADDR_STATUS, 8'h00);
	endtask : t_irq
	task automatic t_az;
		starts(4);
		chk_byte("az runs", 8'h01, runs[7:0]);
		chk_bit("az resume", 1'b0, az_resume);
		csr_host_i.wr_reg(ADDR_AZ_CFG, 8'h82);
		starts(6);
		chk_byte("az runs", 8'h03, runs[7:0]);
		chk_bit("az resume", 1'b1, az_resume);
		csr_host_i.wr_reg(ADDR_AZ_CFG, 8'h00);
		starts(4);
		chk_byte("az runs", 8'h00, runs[7:0]);
	endtask : t_az
	task automatic results;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	// Both resets together, then every scenario in turn
	initial
	begin
		{rst_n, osc_rst_n, power_on, channel_three_select, sat_detect, light_detect, calib_detect} = 7'h00;
		{adc_done, als_cycle_start, base_gain_field} = 4'h0;
		{z_data, y_data, ir1_data, x_data, ir2_data} = 80'h0;
		tick(20);
		{rst_n, osc_rst_n} <= 2'h3;
		tick(10);
		power_on <= 1'b1;
		t_reset();
		t_az();
		t_results();
		t_gain();
		t_irq();
		results();
	end
endmodule : csr_regs_tb
bind csr_regs csr_regs_properties csr_regs_properties_i (.clock, .rst_n, .osc_clock, .osc_rst_n, .power_on,
	.base_gain_field, .int_n_oe, .osc_enable, .gain_select, .als_cycle_start, .az_run);
`default_nettype wire
